// ===== core/bt_addr_decode.sv
`timescale 1ns/10ps
`default_nettype none
module bt_addr_decode
    import bt_pkg::*;
(
    input wire logic [7:0] addr_i,
    output bt_reg_sel_type sel_o
);
`include "bt_params.svh"

    always_comb begin
        case (addr_i)
            `BT_ADDR_NORMAL: sel_o = bt_sel_normal;
            `BT_ADDR_STANDBY: sel_o = bt_sel_standby;
            `BT_ADDR_SLEEP: sel_o = bt_sel_sleep;
            `BT_ADDR_MODE: sel_o = bt_sel_mode;
            `BT_ADDR_CONF: sel_o = bt_sel_conf;
            default: sel_o = bt_sel_none;
        endcase
    end

endmodule
`default_nettype wire

// ===== core/bt_range_load.sv
`timescale 1ns/10ps
`default_nettype none
module bt_range_load
    import bt_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic cfg_load_i,
    input wire logic cfg_range_i,
    input wire logic cfg_done_i,
    output logic range_o,
    output logic locked_o
);
`include "bt_params.svh"

    bt_range_state_type state;
    bt_range_state_type next_state;

    // range may change only while configuration is open
    always_comb begin
        next_state = state;
        case (state.phase)
            bt_cfg_open: begin
                if (cfg_load_i) begin
                    next_state.range = cfg_range_i;
                end
                if (cfg_done_i) begin
                    next_state.phase = bt_cfg_locked;
                end
            end
            bt_cfg_locked: begin
                next_state = state;
            end
            default: begin
                next_state.phase = bt_cfg_locked;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= '{phase: bt_cfg_open, range: `BT_RST_RANGE};
        end else begin
            state <= next_state;
        end
    end

    assign range_o = state.range;
    assign locked_o = state.phase == bt_cfg_locked;

endmodule
`default_nettype wire

// ===== core/bt_regs.sv
`timescale 1ns/10ps
`default_nettype none
// How it works
// R1: five registers at addresses 0x35 to 0x39
// R2: normal setpoint bits 5:0, read/write, reset zero
// R3: normal bit 6 range, read-only, configuration loaded
// R4: standby setpoint bits 5:0, read/write, reset zero
// R5: sleep setpoint bits 5:0, read/write, reset zero
// R6: standby and sleep bit 6 mirror range
// R7: host uses codes 0-63 below 2.0 V
// R8: mode field bits 3:0 read/write
// R9: mode bit 5 selects off or pulse-frequency sleep
// R10: config bit 0 selects low current limit
// R11: config bits 3:2 switching frequency select
// R12: config bits 5:4 phase clock select
// R13: config bits 7:6 voltage slew speed
// R14: unused voltage and mode bits read zero
module bt_regs
    import bt_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    input wire logic cfg_load_i,
    input wire logic cfg_range_i,
    input wire logic cfg_done_i,
    input wire bt_power_state_type power_state_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_ack_o,
    output logic reg_miss_o,
    output logic [5:0] normal_voltage_setpoint_o,
    output logic [5:0] standby_voltage_setpoint_o,
    output logic [5:0] sleep_voltage_setpoint_o,
    output logic voltage_range_o,
    output logic cfg_locked_o,
    output logic [3:0] switching_mode_field_o,
    output logic sleep_state_select_o,
    output logic current_limit_select_o,
    output logic [1:0] switching_frequency_select_o,
    output logic [1:0] phase_clock_select_o,
    output logic [1:0] voltage_slew_speed_select_o,
    output logic [5:0] active_setpoint_o,
    output logic converter_on_o,
    output logic pulse_frequency_operation_o
);
`include "bt_params.svh"

    bt_regs_state_type state;
    bt_regs_state_type next_state;
    bt_reg_sel_type sel;
    logic range;
    logic locked;

    // store only the writable bits; the rest stay zero
    function automatic logic [7:0] bt_masked_write(
        input logic [7:0] old_value,
        input logic [7:0] new_value,
        input logic [7:0] mask
    );
        bt_masked_write = (old_value & ~mask) | (new_value & mask);
    endfunction

    // voltage register read view: setpoint plus range bit
    function automatic logic [7:0] bt_voltage_view(
        input logic [7:0] stored,
        input logic range_bit
    );
        logic [7:0] view;
        view = stored & `BT_MASK_VOLT;
        view[`BT_RANGE_BIT] = range_bit;
        bt_voltage_view = view;
    endfunction

    bt_addr_decode u_decode (
        .addr_i(reg_addr_i),
        .sel_o(sel)
    );

    bt_range_load u_range (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .cfg_load_i(cfg_load_i),
        .cfg_range_i(cfg_range_i),
        .cfg_done_i(cfg_done_i),
        .range_o(range),
        .locked_o(locked)
    );

    always_comb begin
        next_state = state;
        next_state.ack = 1'b0;
        next_state.miss = 1'b0;

        // register writes
        if (reg_wr_i) begin
            case (sel)
                bt_sel_normal: begin
                    next_state.normal = bt_masked_write(state.normal, reg_wdata_i,
                        `BT_MASK_VOLT); // R2 R3 R14
                end
                bt_sel_standby: begin
                    next_state.standby = bt_masked_write(state.standby, reg_wdata_i,
                        `BT_MASK_VOLT); // R4 R14
                end
                bt_sel_sleep: begin
                    next_state.sleep = bt_masked_write(state.sleep, reg_wdata_i,
                        `BT_MASK_VOLT); // R5 R14
                end
                bt_sel_mode: begin
                    next_state.mode = bt_masked_write(state.mode, reg_wdata_i,
                        `BT_MASK_MODE); // R8 R9 R14
                end
                bt_sel_conf: begin
                    next_state.conf = bt_masked_write(state.conf, reg_wdata_i,
                        `BT_MASK_CONF); // R10 R11 R12 R13
                end
                default: begin
                    next_state.miss = 1'b1;
                end
            endcase
        end

        // register reads return the value before any same-cycle write
        if (reg_rd_i) begin
            case (sel)
                bt_sel_normal: begin
                    next_state.rdata = bt_voltage_view(state.normal, range); // R1 R3
                end
                bt_sel_standby: begin
                    next_state.rdata = bt_voltage_view(state.standby, range); // R6
                end
                bt_sel_sleep: begin
                    next_state.rdata = bt_voltage_view(state.sleep, range); // R6
                end
                bt_sel_mode: begin
                    next_state.rdata = state.mode & `BT_MASK_MODE; // R14
                end
                bt_sel_conf: begin
                    next_state.rdata = state.conf;
                end
                default: begin
                    next_state.rdata = 8'h00;
                    next_state.miss = 1'b1;
                end
            endcase
        end

        if (reg_wr_i || reg_rd_i) begin
            next_state.ack = 1'b1;
        end

        // setpoint and run state that the converter uses now
        case (power_state_i)
            bt_pwr_normal: begin
                next_state.active_setpoint = state.normal[`BT_SETPOINT_MSB:`BT_SETPOINT_LSB];
                next_state.converter_on = 1'b1;
                next_state.pulse_freq = 1'b0;
            end
            bt_pwr_standby: begin
                next_state.active_setpoint = state.standby[`BT_SETPOINT_MSB:`BT_SETPOINT_LSB];
                next_state.converter_on = 1'b1;
                next_state.pulse_freq = 1'b0;
            end
            bt_pwr_sleep: begin
                next_state.active_setpoint = state.sleep[`BT_SETPOINT_MSB:`BT_SETPOINT_LSB];
                next_state.converter_on = state.mode[`BT_SLEEP_SEL_BIT]; // R9
                next_state.pulse_freq = state.mode[`BT_SLEEP_SEL_BIT]; // R9
            end
            default: begin
                next_state.active_setpoint = state.normal[`BT_SETPOINT_MSB:`BT_SETPOINT_LSB];
                next_state.converter_on = 1'b1;
                next_state.pulse_freq = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state.normal <= `BT_RST_NORMAL; // R2
            state.standby <= `BT_RST_STANDBY; // R4
            state.sleep <= `BT_RST_SLEEP; // R5
            // reset value wider than the field; only the field bits survive
            state.mode <= `BT_RST_MODE & `BT_MASK_MODE; // R8
            state.conf <= `BT_RST_CONF; // R10 R11 R12 R13
            state.rdata <= 8'h00;
            state.ack <= 1'b0;
            state.miss <= 1'b0;
            state.active_setpoint <= 6'h00;
            state.converter_on <= 1'b0;
            state.pulse_freq <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // outputs taken straight from the state flops
    assign reg_rdata_o = state.rdata;
    assign reg_ack_o = state.ack;
    assign reg_miss_o = state.miss;
    assign normal_voltage_setpoint_o = state.normal[`BT_SETPOINT_MSB:`BT_SETPOINT_LSB];
    assign standby_voltage_setpoint_o = state.standby[`BT_SETPOINT_MSB:`BT_SETPOINT_LSB];
    assign sleep_voltage_setpoint_o = state.sleep[`BT_SETPOINT_MSB:`BT_SETPOINT_LSB];
    assign voltage_range_o = range; // R3 R6
    assign cfg_locked_o = locked;
    assign switching_mode_field_o = state.mode[`BT_MODE_MSB:`BT_MODE_LSB]; // R8
    assign sleep_state_select_o = state.mode[`BT_SLEEP_SEL_BIT]; // R9
    assign current_limit_select_o = state.conf[`BT_ILIM_BIT]; // R10
    assign switching_frequency_select_o = state.conf[`BT_FREQ_MSB:`BT_FREQ_LSB]; // R11
    assign phase_clock_select_o = state.conf[`BT_PHASE_MSB:`BT_PHASE_LSB]; // R12
    assign voltage_slew_speed_select_o = state.conf[`BT_SLEW_MSB:`BT_SLEW_LSB]; // R13
    assign active_setpoint_o = state.active_setpoint;
    assign converter_on_o = state.converter_on;
    assign pulse_frequency_operation_o = state.pulse_freq;

endmodule
`default_nettype wire

// ===== inc/bt_params.svh
`ifndef BT_PARAMS_SVH
`define BT_PARAMS_SVH

// register addresses on the control interface
`define BT_ADDR_NORMAL 8'h35
`define BT_ADDR_STANDBY 8'h36
`define BT_ADDR_SLEEP 8'h37
`define BT_ADDR_MODE 8'h38
`define BT_ADDR_CONF 8'h39

// field positions
`define BT_SETPOINT_MSB 5
`define BT_SETPOINT_LSB 0
`define BT_RANGE_BIT 6
`define BT_MODE_MSB 3
`define BT_MODE_LSB 0
`define BT_SLEEP_SEL_BIT 5
`define BT_ILIM_BIT 0
`define BT_FREQ_MSB 3
`define BT_FREQ_LSB 2
`define BT_PHASE_MSB 5
`define BT_PHASE_LSB 4
`define BT_SLEW_MSB 7
`define BT_SLEW_LSB 6

// reset values
`define BT_RST_NORMAL 8'h00
`define BT_RST_STANDBY 8'h00
`define BT_RST_SLEEP 8'h00
`define BT_RST_MODE 8'h80
`define BT_RST_CONF 8'h00
`define BT_RST_RANGE 1'b0

// writable bits of each register
`define BT_MASK_VOLT 8'h3f
`define BT_MASK_MODE 8'h2f
`define BT_MASK_CONF 8'hff

`endif

// ===== inc/bt_pkg.sv
package bt_pkg;

    typedef enum logic [2:0] {
        bt_sel_normal,
        bt_sel_standby,
        bt_sel_sleep,
        bt_sel_mode,
        bt_sel_conf,
        bt_sel_none
    } bt_reg_sel_type;

    typedef enum logic [1:0] {
        bt_pwr_normal,
        bt_pwr_standby,
        bt_pwr_sleep
    } bt_power_state_type;

    typedef enum logic {
        bt_cfg_open,
        bt_cfg_locked
    } bt_cfg_phase_type;

    typedef struct packed {
        bt_cfg_phase_type phase;
        logic range;
    } bt_range_state_type;

    typedef struct packed {
        logic [7:0] normal;
        logic [7:0] standby;
        logic [7:0] sleep;
        logic [7:0] mode;
        logic [7:0] conf;
        logic [7:0] rdata;
        logic ack;
        logic miss;
        logic [5:0] active_setpoint;
        logic converter_on;
        logic pulse_freq;
    } bt_regs_state_type;

endpackage

// ===== verification/bt_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module bt_host_model (
    input wire logic core_clk_i,
    input wire logic [7:0] reg_rdata_i,
    input wire logic reg_ack_i,
    input wire logic reg_miss_i,
    output logic [7:0] reg_addr_o,
    output logic reg_wr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_rd_o
);
    initial begin
        reg_addr_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_wdata_o = 8'h00;
        reg_rd_o = 1'b0;
    end
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic miss, output logic ok);
        ok = 1'b0;
        @(negedge core_clk_i);
        reg_addr_o = a;
        // set-point writes sent with bit 6 cleared; bit 7 passes through
        reg_wdata_o = (a >= 8'h35 && a <= 8'h37) ? (d & 8'hbf) : d;
        reg_wr_o = wr;
        reg_rd_o = !wr;
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk_i);
            #1;
            if (reg_ack_i === 1'b1) begin
                q = reg_rdata_i;
                miss = reg_miss_i;
                ok = 1'b1;
                break;
            end
        end
        @(negedge core_clk_i);
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== verification/bt_regs_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module bt_regs_asserts (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    input wire logic cfg_load_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic reg_ack_o,
    input wire logic reg_miss_o,
    input wire logic [5:0] normal_voltage_setpoint_o,
    input wire logic [5:0] standby_voltage_setpoint_o,
    input wire logic [5:0] sleep_voltage_setpoint_o,
    input wire logic voltage_range_o,
    input wire logic cfg_locked_o,
    input wire logic [3:0] switching_mode_field_o,
    input wire logic sleep_state_select_o,
    input wire logic current_limit_select_o,
    input wire logic [1:0] switching_frequency_select_o,
    input wire logic [1:0] phase_clock_select_o,
    input wire logic [1:0] voltage_slew_speed_select_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_req; reg_wr_i || reg_rd_i; endsequence
    sequence s_wr(a); reg_wr_i && reg_addr_i == a; endsequence
    sequence s_rd(a); reg_rd_i && reg_addr_i == a; endsequence
    ack_timing_a: assert property (s_req |=> reg_ack_o)
        else $error("no ack one cycle after request");
    ack_only_a: assert property (!(reg_wr_i || reg_rd_i) |=> !reg_ack_o)
        else $error("ack without request");
    miss_map_a: assert property (s_req |=> reg_miss_o ==
        ($past(reg_addr_i) < 8'h35 || $past(reg_addr_i) > 8'h39)) else $error("miss wrong");
    norm_wr_a: assert property (s_wr(8'h35) |=>
        normal_voltage_setpoint_o == $past(reg_wdata_i[5:0])) else $error("setpoint not written");
    mode_wr_a: assert property (s_wr(8'h38) |=> {switching_mode_field_o, sleep_state_select_o}
        == {$past(reg_wdata_i[3:0]), $past(reg_wdata_i[5])}) else $error("mode not written");
    conf_wr_a: assert property (s_wr(8'h39) |=> {voltage_slew_speed_select_o,
        phase_clock_select_o, switching_frequency_select_o, current_limit_select_o}
        == {$past(reg_wdata_i[7:2]), $past(reg_wdata_i[0])}) else $error("config not written");
    norm_rd_a: assert property (s_rd(8'h35) |=> reg_rdata_o == {1'b0,
        $past(voltage_range_o), $past(normal_voltage_setpoint_o)}) else $error("bad read");
    mode_rd_a: assert property (s_rd(8'h38) |=> reg_rdata_o == {2'b00,
        $past(sleep_state_select_o), 1'b0, $past(switching_mode_field_o)}) else $error("bad read");
    range_load_a: assert property ($changed(voltage_range_o) |-> $past(cfg_load_i))
        else $error("range moved without load");
    stby_wr_a: assert property (s_wr(8'h36) |=>
        standby_voltage_setpoint_o == $past(reg_wdata_i[5:0])) else $error("standby not written");
    slp_wr_a: assert property (s_wr(8'h37) |=>
        sleep_voltage_setpoint_o == $past(reg_wdata_i[5:0])) else $error("sleep not written");
    range_lock_a: assert property ($changed(voltage_range_o) |-> !$past(cfg_locked_o))
        else $error("range moved after lock");
    rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved without read");
endmodule
bind bt_regs bt_regs_asserts u_chk (.*);
`default_nettype wire

// ===== verification/bt_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module bt_regs_tb;
    import bt_pkg::*;
    `define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
        $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic cfg_load_i = 1'b0;
    logic cfg_range_i = 1'b0;
    logic cfg_done_i = 1'b0;
    bt_power_state_type power_state_i = bt_pwr_normal;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
    logic reg_wr_i, reg_rd_i, reg_ack_o, reg_miss_o, voltage_range_o, cfg_locked_o;
    logic [5:0] normal_voltage_setpoint_o, standby_voltage_setpoint_o;
    logic [5:0] sleep_voltage_setpoint_o, active_setpoint_o;
    logic [3:0] switching_mode_field_o;
    logic sleep_state_select_o, current_limit_select_o;
    logic converter_on_o, pulse_frequency_operation_o;
    logic [1:0] switching_frequency_select_o, phase_clock_select_o;
    logic [1:0] voltage_slew_speed_select_o;
    int n_errors = 0;
    int n_tests = 0;
    always #20 core_clk_i = ~core_clk_i;
    bt_regs dut (.*);
    bt_host_model host (.core_clk_i(core_clk_i), .reg_rdata_i(reg_rdata_o),
        .reg_ack_i(reg_ack_o), .reg_miss_i(reg_miss_o), .reg_addr_o(reg_addr_i),
        .reg_wr_o(reg_wr_i), .reg_wdata_o(reg_wdata_i), .reg_rd_o(reg_rd_i));
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        input logic [7:0] e, input logic em);
        logic [7:0] q;
        logic m;
        logic ok;
        host.access(wr, a, d, q, m, ok);
        `CHK(ok, 1'b1)
        if (ok !== 1'b1) final_report();
        if (!wr) `CHK(q, e)
        `CHK(m, em)
    endtask
    task automatic cfg(input logic ld, input logic rng, input logic dn);
        @(negedge core_clk_i);
        cfg_load_i = ld;
        cfg_range_i = rng;
        cfg_done_i = dn;
    endtask
    initial begin
        repeat (12) @(negedge core_clk_i);
        rst_n_i = 1'b1;
        for (int i = 0; i < 5; i++) begin
            xfer(1'b0, 8'h35 + i[7:0], 8'h00, 8'h00, 1'b0);
        end
        `CHK({cfg_locked_o, voltage_range_o}, 2'b00)
        $display("test reset values done");
        xfer(1'b1, 8'h35, 8'hbf, 8'h00, 1'b0);
        xfer(1'b1, 8'h36, 8'h95, 8'h00, 1'b0);
        xfer(1'b1, 8'h37, 8'h2a, 8'h00, 1'b0);
        xfer(1'b1, 8'h38, 8'hff, 8'h00, 1'b0);
        xfer(1'b1, 8'h39, 8'h6d, 8'h00, 1'b0);
        xfer(1'b0, 8'h35, 8'h00, 8'h3f, 1'b0);
        xfer(1'b0, 8'h36, 8'h00, 8'h15, 1'b0);
        xfer(1'b0, 8'h37, 8'h00, 8'h2a, 1'b0);
        xfer(1'b0, 8'h38, 8'h00, 8'h2f, 1'b0);
        xfer(1'b0, 8'h39, 8'h00, 8'h6d, 1'b0);
        `CHK({voltage_slew_speed_select_o, phase_clock_select_o}, 4'h6)
        `CHK({switching_frequency_select_o, current_limit_select_o}, 3'h7)
        `CHK({switching_mode_field_o, sleep_state_select_o}, 5'h1f)
        `CHK({normal_voltage_setpoint_o, standby_voltage_setpoint_o}, 12'hfd5)
        `CHK(sleep_voltage_setpoint_o, 6'h2a)
        `CHK({converter_on_o, pulse_frequency_operation_o, active_setpoint_o}, 8'hbf)
        $display("test field write done");
        xfer(1'b1, 8'h3a, 8'hff, 8'h00, 1'b1);
        xfer(1'b0, 8'h3a, 8'h00, 8'h00, 1'b1);
        xfer(1'b0, 8'h34, 8'h00, 8'h00, 1'b1);
        xfer(1'b0, 8'h39, 8'h00, 8'h6d, 1'b0);
        $display("test address map done");
        cfg(1'b1, 1'b1, 1'b0);
        cfg(1'b0, 1'b0, 1'b1);
        cfg(1'b1, 1'b0, 1'b0);
        cfg(1'b0, 1'b0, 1'b0);
        `CHK({cfg_locked_o, voltage_range_o}, 2'b11)
        xfer(1'b1, 8'h35, 8'h00, 8'h00, 1'b0);
        xfer(1'b0, 8'h35, 8'h00, 8'h40, 1'b0);
        xfer(1'b0, 8'h36, 8'h00, 8'h55, 1'b0);
        xfer(1'b0, 8'h37, 8'h00, 8'h6a, 1'b0);
        $display("test range bit done");
        @(negedge core_clk_i);
        power_state_i = bt_pwr_standby;
        repeat (2) @(negedge core_clk_i);
        `CHK({converter_on_o, pulse_frequency_operation_o, active_setpoint_o}, 8'h95)
        power_state_i = bt_pwr_sleep;
        repeat (2) @(negedge core_clk_i);
        `CHK({converter_on_o, pulse_frequency_operation_o, active_setpoint_o}, 8'hea)
        xfer(1'b1, 8'h38, 8'h0f, 8'h00, 1'b0);
        repeat (2) @(negedge core_clk_i);
        `CHK({converter_on_o, pulse_frequency_operation_o}, 2'b00)
        $display("test sleep state done");
        @(negedge core_clk_i);
        rst_n_i = 1'b0;
        @(negedge core_clk_i);
        `CHK({cfg_locked_o, voltage_range_o, normal_voltage_setpoint_o}, 8'h00)
        rst_n_i = 1'b1;
        xfer(1'b0, 8'h39, 8'h00, 8'h00, 1'b0);
        cfg(1'b1, 1'b1, 1'b0);
        cfg(1'b0, 1'b0, 1'b0);
        xfer(1'b0, 8'h37, 8'h00, 8'h40, 1'b0);
        $display("test mid-run reset done");
        final_report();
    end
endmodule
`default_nettype wire
